//--- include/uc_serial_control_defs.vh
// register map, field positions and reset values of the serial control block
// How it works
// RULE_01 - control register is 8 bits, cleared by reset and low-power entry
// RULE_02 - software reads and writes every control bit at any time
// RULE_03 - transmit-empty request is tx_irq_en and tx_holding_empty together
// RULE_04 - rx_irq_en gates both receive-full and receive-error requests
// RULE_05 - receive requests drop when flag or rx_irq_en clears
// RULE_06 - tx_holding_empty held at one while tx_on is zero
// RULE_07 - data write with tx_on clears tx_holding_empty and starts shifting
// RULE_08 - software sets frame format before enabling transmit or receive
// RULE_09 - transmit pin is serial output only while its port select is one
// RULE_10 - receive pin is general port unless rx_on is one
// RULE_11 - clearing rx_on leaves receive flags untouched
// RULE_12 - with rx_on, reception starts on start bit or serial clock
// RULE_13 - wake_on_tag counts only in asynchronous multiprocessor format
// RULE_14 - while waiting for tag, untagged characters are silently dropped
// RULE_15 - tagged character sets rx_tag_bit and clears wake_on_tag
// RULE_16 - transmit-end request when last bit due and holding empty
// RULE_17 - transmit-end request drops on new data or tx_end_irq_en clear
// RULE_18 - async internal clock with clk_out_sel drives bit-rate clock out
// RULE_19 - remote supplies sixteen-times clock in async external mode
// RULE_20 - synchronous mode drives clock when clk_src_sel zero, else inputs
// RULE_21 - software keeps clk_out_sel zero when not meaningful
// RULE_22 - link_style zero is asynchronous, one is clocked synchronous
// RULE_23 - tx_holding_empty set on each move to shifter and when disabled
// RULE_24 - every request is a level while enable and source both hold
`ifndef UC_SERIAL_CONTROL_DEFS_VH
`define UC_SERIAL_CONTROL_DEFS_VH
`define UC_ADDR_W 8
`define UC_REG_CTRL 8'h00
`define UC_REG_CFG 8'h04
`define UC_REG_STAT 8'h08
`define UC_REG_TXD 8'h0C
`define UC_REG_RXD 8'h10
`define UC_CTRL_TIE 7
`define UC_CTRL_RIE 6
`define UC_CTRL_TE 5
`define UC_CTRL_RE 4
`define UC_CTRL_WAKE_ON_TAG 3
`define UC_CTRL_TX_END_IRQ_EN 2
`define UC_CTRL_CLK_SRC_SEL 1
`define UC_CTRL_CLK_OUT_SEL 0
`define UC_CFG_STYLE 0
`define UC_CFG_TAG 1
`define UC_CFG_TXSEL 2
`define UC_STAT_TX_HOLDING_EMPTY 7
`define UC_STAT_RX_HOLDING_FULL 6
`define UC_STAT_OER 5
`define UC_STAT_FER 4
`define UC_STAT_PER 3
`define UC_STAT_TX_DONE_FLAG 2
`define UC_STAT_MPB 1
`define UC_CTRL_RST 8'h00
`define UC_CFG_RST 8'h00
`define UC_TXD_RST 8'hFF
`define UC_RXD_RST 8'h00
`define UC_RESP_OK 2'h0
`define UC_RESP_SLVERR 2'h2
`endif

//--- src/uc_serial_control.v
// serial unit control register, flag gating, interrupt levels and pin routing
`include "uc_serial_control_defs.vh"
module uc_serial_control (
  input wire core_clk_in,
  input wire rst_in,
  input wire low_power_in,
  input wire [`UC_ADDR_W-1:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [`UC_ADDR_W-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire tx_load_in,
  input wire tx_last_bit_in,
  input wire tx_serial_in,
  input wire rx_done_in,
  input wire [7:0] rx_data_in,
  input wire rx_tag_in,
  input wire rx_frame_err_in,
  input wire rx_parity_err_in,
  input wire half_bit_tick_in,
  input wire tx_port_data_in,
  input wire tx_port_oe_in,
  input wire sclk_port_data_in,
  input wire sclk_port_oe_in,
  input wire rx_pin_in,
  input wire serial_clk_pin_in,
  output reg tx_pin_out,
  output reg tx_pin_oe_out,
  output reg serial_clk_pin_out,
  output reg serial_clk_pin_oe_out,
  output reg rx_serial_out,
  output reg rx_port_out,
  output reg sclk_port_out,
  output reg rx_start_out,
  output reg tx_start_out,
  output reg [7:0] tx_holding_out,
  output reg link_style_out,
  output reg tx_empty_irq_out,
  output reg rx_full_irq_out,
  output reg rx_error_irq_out,
  output reg tx_end_irq_out
);
  reg [7:0] serial_control;
  reg [7:0] cfg;
  reg [7:0] rx_holding;
  reg tx_holding_empty;
  reg rx_holding_full;
  reg overrun_flag;
  reg frame_fault;
  reg parity_fault;
  reg tx_done_flag;
  reg rx_tag_bit;
  reg aw_got;
  reg w_got;
  reg [`UC_ADDR_W-1:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane0;
  reg rx_s1;
  reg rx_s2;
  reg rx_s3;
  reg ck_s1;
  reg ck_s2;
  reg ck_s3;
  reg sclk_level;
  reg [7:0] rd_value;
  reg rd_hit;

  wire clr_all = rst_in | low_power_in;
  wire tx_on = serial_control[`UC_CTRL_TE];
  wire rx_on = serial_control[`UC_CTRL_RE];
  wire clk_src_sel = serial_control[`UC_CTRL_CLK_SRC_SEL];
  wire clk_out_sel = serial_control[`UC_CTRL_CLK_OUT_SEL];
  wire link_style = cfg[`UC_CFG_STYLE];
  wire tag_format = cfg[`UC_CFG_TAG];
  wire wr_fire = aw_got & w_got & ~s_axi_bvalid_out;
  wire wr_lane = wr_fire & w_lane0;
  wire rd_fire = s_axi_arvalid_in & s_axi_arready_out;
  wire wr_ctrl = wr_lane & (aw_addr == `UC_REG_CTRL);
  wire wr_cfg = wr_lane & (aw_addr == `UC_REG_CFG);
  wire wr_stat = wr_lane & (aw_addr == `UC_REG_STAT);
  wire wr_txd = wr_lane & (aw_addr == `UC_REG_TXD);
  wire rd_rxd = rd_fire & (s_axi_araddr_in == `UC_REG_RXD);
  // wake gating has no meaning outside async multiprocessor format
  wire wake_active = serial_control[`UC_CTRL_WAKE_ON_TAG] & ~link_style & tag_format; // RULE_13 RULE_22
  wire rx_event = rx_done_in & rx_on;
  wire rx_drop = rx_event & wake_active & ~rx_tag_in; // RULE_14
  wire rx_take = rx_event & ~rx_drop;
  wire wake_hit = rx_event & wake_active & rx_tag_in; // RULE_15
  wire sclk_drive = ~clk_src_sel & (link_style ? ~clk_out_sel : clk_out_sel); // RULE_18 RULE_20
  wire sclk_input = clk_src_sel & ~clk_out_sel; // RULE_20
  wire ext_rise = sclk_input & ck_s2 & ~ck_s3;
  wire int_rise = sclk_drive & half_bit_tick_in & ~sclk_level;
  wire sclk_edge = ext_rise | int_rise;

  // write address and data are taken independently, answered once both are in
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      aw_got <= 1'h0;
      w_got <= 1'h0;
      aw_addr <= {`UC_ADDR_W{1'h0}};
      w_byte <= 8'h00;
      w_lane0 <= 1'h0;
      s_axi_awready_out <= 1'h0;
      s_axi_wready_out <= 1'h0;
      s_axi_bvalid_out <= 1'h0;
      s_axi_bresp_out <= `UC_RESP_OK;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got <= 1'h1;
        aw_addr <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'h0;
      end else if (!aw_got && !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'h1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got <= 1'h1;
        w_byte <= s_axi_wdata_in[7:0];
        w_lane0 <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'h0;
      end else if (!w_got && !s_axi_bvalid_out) begin
        s_axi_wready_out <= 1'h1;
      end
      if (wr_fire) begin
        aw_got <= 1'h0;
        w_got <= 1'h0;
        s_axi_bvalid_out <= 1'h1;
        if (aw_addr == `UC_REG_CTRL || aw_addr == `UC_REG_CFG || aw_addr == `UC_REG_STAT ||
            aw_addr == `UC_REG_TXD || aw_addr == `UC_REG_RXD) begin
          s_axi_bresp_out <= `UC_RESP_OK;
        end else begin
          s_axi_bresp_out <= `UC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'h0;
      end
    end
  end

  always @* begin
    rd_hit = 1'h1;
    if (s_axi_araddr_in == `UC_REG_CTRL) begin
      rd_value = serial_control; // RULE_02
    end else if (s_axi_araddr_in == `UC_REG_CFG) begin
      rd_value = cfg;
    end else if (s_axi_araddr_in == `UC_REG_STAT) begin
      rd_value = {tx_holding_empty, rx_holding_full, overrun_flag, frame_fault,
                  parity_fault, tx_done_flag, rx_tag_bit, 1'h0};
    end else if (s_axi_araddr_in == `UC_REG_TXD) begin
      rd_value = tx_holding_out;
    end else if (s_axi_araddr_in == `UC_REG_RXD) begin
      rd_value = rx_holding;
    end else begin
      rd_value = 8'h00;
      rd_hit = 1'h0;
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'h0;
      s_axi_rvalid_out <= 1'h0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `UC_RESP_OK;
    end else if (rd_fire) begin
      s_axi_arready_out <= 1'h0;
      s_axi_rvalid_out <= 1'h1;
      s_axi_rdata_out <= {24'h000000, rd_value};
      s_axi_rresp_out <= rd_hit ? `UC_RESP_OK : `UC_RESP_SLVERR;
    end else if (s_axi_rvalid_out) begin
      if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'h0;
      end
    end else begin
      s_axi_arready_out <= 1'h1;
    end
  end

  // control and format bits; hardware clearing of wake_on_tag yields to a same-cycle write
  always @(posedge core_clk_in) begin
    if (clr_all) begin
      serial_control <= `UC_CTRL_RST; // RULE_01
      cfg <= `UC_CFG_RST;
    end else begin
      if (wake_hit) begin
        serial_control[`UC_CTRL_WAKE_ON_TAG] <= 1'h0; // RULE_15
      end
      if (wr_ctrl) begin
        serial_control <= w_byte; // RULE_02
      end
      if (wr_cfg) begin
        cfg <= w_byte;
      end
    end
  end

  // status flags: software clears the holding and error flags by writing zero, hardware sets win over any clear
  always @(posedge core_clk_in) begin
    if (clr_all) begin
      tx_holding_empty <= 1'h1;
      rx_holding_full <= 1'h0;
      overrun_flag <= 1'h0;
      frame_fault <= 1'h0;
      parity_fault <= 1'h0;
      tx_done_flag <= 1'h1;
      rx_tag_bit <= 1'h0;
      tx_holding_out <= `UC_TXD_RST;
      rx_holding <= `UC_RXD_RST;
      tx_start_out <= 1'h0;
    end else begin
      tx_start_out <= wr_txd & tx_on; // RULE_07
      if (wr_stat) begin
        if (!w_byte[`UC_STAT_TX_HOLDING_EMPTY]) tx_holding_empty <= 1'h0;
        if (!w_byte[`UC_STAT_RX_HOLDING_FULL]) rx_holding_full <= 1'h0;
        if (!w_byte[`UC_STAT_OER]) overrun_flag <= 1'h0;
        if (!w_byte[`UC_STAT_FER]) frame_fault <= 1'h0;
        if (!w_byte[`UC_STAT_PER]) parity_fault <= 1'h0;
      end
      if (wr_txd) begin
        tx_holding_out <= w_byte;
        if (tx_on) begin
          tx_holding_empty <= 1'h0; // RULE_07
          tx_done_flag <= 1'h0; // RULE_17
        end
      end
      if (rd_rxd) begin
        rx_holding_full <= 1'h0;
      end
      if (!tx_on || tx_load_in) begin
        tx_holding_empty <= 1'h1; // RULE_06 RULE_23
      end
      if (tx_last_bit_in && tx_holding_empty) begin
        tx_done_flag <= 1'h1; // RULE_16
      end
      // flags are set only on a kept character, never cleared by rx_on going low
      if (rx_take) begin // RULE_11 RULE_14
        if (tag_format && !link_style) begin
          rx_tag_bit <= rx_tag_in; // RULE_15
        end
        if (rx_holding_full) begin
          overrun_flag <= 1'h1;
        end else if (!link_style && rx_frame_err_in) begin
          frame_fault <= 1'h1;
          rx_holding <= rx_data_in;
        end else if (!link_style && !tag_format && rx_parity_err_in) begin
          parity_fault <= 1'h1;
          rx_holding <= rx_data_in;
        end else begin
          rx_holding_full <= 1'h1;
          rx_holding <= rx_data_in;
        end
      end
    end
  end

  // request levels follow enable and source with one register stage
  always @(posedge core_clk_in) begin
    if (clr_all) begin
      tx_empty_irq_out <= 1'h0;
      rx_full_irq_out <= 1'h0;
      rx_error_irq_out <= 1'h0;
      tx_end_irq_out <= 1'h0;
    end else begin
      tx_empty_irq_out <= serial_control[`UC_CTRL_TIE] & tx_holding_empty; // RULE_03 RULE_24
      rx_full_irq_out <= serial_control[`UC_CTRL_RIE] & rx_holding_full; // RULE_04 RULE_05
      rx_error_irq_out <= serial_control[`UC_CTRL_RIE] &
                          (overrun_flag | frame_fault | parity_fault); // RULE_04 RULE_05 RULE_24
      tx_end_irq_out <= serial_control[`UC_CTRL_TX_END_IRQ_EN] & tx_done_flag; // RULE_16 RULE_17
    end
  end

  // pin inputs cross in through two flops; the third only feeds edge detection
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_s1 <= 1'h1;
      rx_s2 <= 1'h1;
      rx_s3 <= 1'h1;
      ck_s1 <= 1'h0;
      ck_s2 <= 1'h0;
      ck_s3 <= 1'h0;
    end else begin
      rx_s1 <= rx_pin_in;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      ck_s1 <= serial_clk_pin_in;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
    end
  end

  // bit-rate clock: toggles on each half-bit tick while this end drives the pin
  always @(posedge core_clk_in) begin
    if (clr_all) begin
      sclk_level <= 1'h0;
    end else if (!sclk_drive) begin
      sclk_level <= 1'h0;
    end else if (half_bit_tick_in) begin
      sclk_level <= ~sclk_level; // RULE_18
    end
  end

  always @(posedge core_clk_in) begin
    if (clr_all) begin
      tx_pin_out <= 1'h1;
      tx_pin_oe_out <= 1'h0;
      serial_clk_pin_out <= 1'h0;
      serial_clk_pin_oe_out <= 1'h0;
      rx_serial_out <= 1'h1;
      rx_port_out <= 1'h1;
      sclk_port_out <= 1'h0;
      rx_start_out <= 1'h0;
      link_style_out <= 1'h0;
    end else begin
      link_style_out <= link_style; // RULE_22
      // with its port select at one, a disabled transmitter still owns the pin and idles at mark
      if (cfg[`UC_CFG_TXSEL]) begin
        tx_pin_out <= tx_on ? tx_serial_in : 1'h1; // RULE_09
        tx_pin_oe_out <= 1'h1;
      end else begin
        tx_pin_out <= tx_port_data_in; // RULE_09
        tx_pin_oe_out <= tx_port_oe_in;
      end
      if (sclk_drive) begin
        serial_clk_pin_out <= sclk_level; // RULE_18 RULE_20
        serial_clk_pin_oe_out <= 1'h1;
      end else if (sclk_input) begin
        serial_clk_pin_out <= 1'h0; // RULE_19 RULE_20
        serial_clk_pin_oe_out <= 1'h0;
      end else begin
        serial_clk_pin_out <= sclk_port_data_in; // RULE_18 RULE_21
        serial_clk_pin_oe_out <= sclk_port_oe_in;
      end
      sclk_port_out <= ck_s2;
      rx_serial_out <= rx_on ? rx_s2 : 1'h1; // RULE_10
      rx_port_out <= rx_on ? 1'h1 : rx_s2; // RULE_10
      // start-bit detection relies on the format being fixed before rx_on rises
      rx_start_out <= rx_on & (link_style ? sclk_edge : (rx_s3 & ~rx_s2)); // RULE_12 RULE_08
    end
  end
endmodule

//--- tb/uc_serial_control_monitor.sv
// port assertions and covers for the serial control block
module uc_serial_control_monitor (
  input wire core_clk_in,
  input wire rst_in,
  input wire low_power_in,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0] s_axi_rresp_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_awready_out,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire half_bit_tick_in,
  input wire serial_clk_pin_out,
  input wire serial_clk_pin_oe_out,
  input wire rx_serial_out,
  input wire rx_port_out,
  input wire rx_start_out,
  input wire tx_start_out,
  input wire [7:0] tx_holding_out,
  input wire tx_empty_irq_out,
  input wire rx_full_irq_out,
  input wire rx_error_irq_out,
  input wire tx_end_irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  AST_LP_CLR: assert property (low_power_in |=> tx_holding_out == 8'hFF &&
    !(tx_empty_irq_out | rx_full_irq_out | rx_error_irq_out | tx_end_irq_out)) else $error("low power left state");
  AST_CTRL_8BIT: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 8'h00
    |=> s_axi_rvalid_out && s_axi_rdata_out[31:8] == 24'h0 && s_axi_rresp_out == 2'h0) else $error("control read bad");
  AST_RX_ROUTE: assert property (rx_serial_out || rx_port_out) else $error("rx pin owned twice");
  AST_TX_START: assert property (tx_start_out |-> !s_axi_awready_out ##1 !tx_start_out)
    else $error("tx start not a write pulse");
  AST_RX_START: assert property (rx_start_out |=> !rx_start_out) else $error("rx start too long");
  AST_CLK_TICK: assert property ($past(serial_clk_pin_oe_out) && serial_clk_pin_oe_out
    && $changed(serial_clk_pin_out) |-> $past(half_bit_tick_in, 2)) else $error("clock out moved off tick");
  AST_B_BUSY: assert property ($rose(s_axi_bvalid_out) |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write ready during response");
  AST_R_BUSY: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read ready in response");
  COV_TX: cover property (tx_start_out);
  COV_RX: cover property (rx_start_out);
  COV_TEI: cover property ($rose(tx_end_irq_out));
  COV_ERI: cover property ($rose(rx_error_irq_out));
endmodule

//--- tb/uc_remote_node.sv
// remote serial node driving the receive and clock pins
module uc_remote_node (
  output logic rx_line_out,
  output logic clk_line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // line idles at mark, clock stands high between frames
  initial begin
    rx_line_out = 1'b1;
    clk_line_out = 1'b1;
  end
  task automatic send_async(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    #1.3;
    for (int i = 0; i < 10; i++) begin
      rx_line_out = f[i];
      repeat (16) begin
        #16 clk_line_out = 1'b0;
        #16 clk_line_out = 1'b1;
      end
    end
  endtask
  // offset keeps the link out of phase with the core clock
  task automatic send_sync(input logic [7:0] d);
    #1.3;
    for (int i = 0; i < 8; i++) begin
      #16 clk_line_out = 1'b0;
      rx_line_out = d[i];
      #16 clk_line_out = 1'b1;
    end
    rx_line_out = 1'b1;
  endtask
endmodule

//--- tb/tb_uc_serial_control.sv
// register-level bench for the serial control block
`include "uc_serial_control_defs.vh"
module tb_uc_serial_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_in = 0, rst_in = 1, low_power_in = 0, tx_load_in = 0, tx_last_bit_in = 0, rx_done_in = 0;
  logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0, rx_data_in = 0;
  logic [31:0] s_axi_wdata_in = 0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic tx_serial_in = 1, rx_tag_in = 0, rx_frame_err_in = 0, rx_parity_err_in = 0, half_bit_tick_in = 0;
  logic tx_port_data_in = 0, tx_port_oe_in = 0, sclk_port_data_in = 0, sclk_port_oe_in = 0;
  wire rx_pin_in, serial_clk_pin_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  wire s_axi_rvalid_out, tx_pin_out, tx_pin_oe_out, serial_clk_pin_out, serial_clk_pin_oe_out, rx_serial_out;
  wire rx_port_out, sclk_port_out, rx_start_out, tx_start_out, link_style_out, tx_empty_irq_out;
  wire rx_full_irq_out, rx_error_irq_out, tx_end_irq_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire [7:0] tx_holding_out;
  int error_cnt = 0, n_tests = 0, cyc = 0, starts = 0, s0 = 0;
  logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
  logic [9:0] ck [6] = '{10'h000, 10'h101, 10'h002, 10'h300, 10'h202, 10'h201};
  uc_serial_control i_uc_serial_control (.*);
  uc_remote_node i_uc_remote_node (.rx_line_out(rx_pin_in), .clk_line_out(serial_clk_pin_in));
  always #2 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    half_bit_tick_in <= (cyc % 8 == 0);
    if (rx_start_out === 1'b1) starts++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic pa = 1, pw = 1;
    @(posedge core_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, d};
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    s_axi_bready_in <= 1;
    while (pa | pw) begin
      @(posedge core_clk_in);
      if (s_axi_awready_out === 1'b1) pa = 0;
      if (s_axi_wready_out === 1'b1) pw = 0;
      s_axi_awvalid_in <= pa;
      s_axi_wvalid_in <= pw;
    end
    do @(posedge core_clk_in); while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 0;
    chk(s_axi_bresp_out, er);
    repeat (2) @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = 2'h0);
    @(posedge core_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    s_axi_rready_in <= 1;
    do @(posedge core_clk_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 0;
    do @(posedge core_clk_in); while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 0;
    chk(s_axi_rdata_out, {24'h0, e});
    chk(s_axi_rresp_out, er);
    repeat (2) @(posedge core_clk_in);
  endtask
  // one-cycle strobes: low power, shifter load, last bit
  task automatic pul(input logic [2:0] w);
    @(posedge core_clk_in);
    {low_power_in, tx_load_in, tx_last_bit_in} <= w;
    @(posedge core_clk_in);
    {low_power_in, tx_load_in, tx_last_bit_in} <= 3'h0;
    repeat (3) @(posedge core_clk_in);
  endtask
  task automatic rxc(input logic [7:0] d, input logic t, input logic [1:0] e);
    @(posedge core_clk_in);
    rx_data_in <= d;
    rx_tag_in <= t;
    {rx_frame_err_in, rx_parity_err_in} <= e;
    rx_done_in <= 1;
    @(posedge core_clk_in);
    rx_done_in <= 0;
    repeat (3) @(posedge core_clk_in);
  endtask
  task automatic t_end(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_in <= 0;
    rd(`UC_REG_CTRL, 8'h00);
    rd(`UC_REG_STAT, 8'h84);
    rd(8'h14, 8'h00, 2'h2);
    wr(8'h14, 8'h55, 2'h2);
    t_end("reset");
    foreach (pat[i]) begin
      wr(`UC_REG_CTRL, pat[i]);
      rd(`UC_REG_CTRL, pat[i]);
    end
    s_axi_wstrb_in <= 4'hE;
    wr(`UC_REG_CTRL, 8'hFF);
    s_axi_wstrb_in <= 4'hF;
    rd(`UC_REG_CTRL, 8'h00);
    wr(`UC_REG_CTRL, 8'hFF);
    pul(3'h4);
    rd(`UC_REG_CTRL, 8'h00);
    t_end("regs");
    wr(`UC_REG_CFG, 8'h00);
    wr(`UC_REG_CTRL, 8'hA0);
    chk(tx_empty_irq_out, 1);
    wr(`UC_REG_TXD, 8'h3C);
    chk(tx_empty_irq_out, 0);
    chk(tx_holding_out, 8'h3C);
    pul(3'h2);
    chk(tx_empty_irq_out, 1);
    wr(`UC_REG_TXD, 8'hC3);
    wr(`UC_REG_CTRL, 8'h80);
    chk(tx_empty_irq_out, 1);
    wr(`UC_REG_CTRL, 8'h00);
    chk(tx_empty_irq_out, 0);
    wr(`UC_REG_CTRL, 8'h24);
    pul(3'h1);
    chk(tx_end_irq_out, 1);
    wr(`UC_REG_TXD, 8'h0F);
    chk(tx_end_irq_out, 0);
    pul(3'h1);
    chk(tx_end_irq_out, 0);
    pul(3'h2);
    pul(3'h1);
    chk(tx_end_irq_out, 1);
    wr(`UC_REG_CTRL, 8'h20);
    chk(tx_end_irq_out, 0);
    t_end("tx");
    wr(`UC_REG_CTRL, 8'h50);
    rxc(8'h96, 0, 2'h0);
    chk(rx_full_irq_out, 1);
    rxc(8'h69, 0, 2'h0);
    chk(rx_error_irq_out, 1);
    wr(`UC_REG_CTRL, 8'h40);
    rd(`UC_REG_STAT, 8'hE4);
    rd(`UC_REG_RXD, 8'h96);
    chk(rx_full_irq_out, 0);
    wr(`UC_REG_STAT, 8'h00);
    chk(rx_error_irq_out, 0);
    wr(`UC_REG_CTRL, 8'h50);
    rxc(8'h33, 0, 2'h3);
    chk({rx_error_irq_out, rx_full_irq_out}, 2'b10);
    wr(`UC_REG_CTRL, 8'h10);
    chk(rx_error_irq_out, 0);
    wr(`UC_REG_STAT, 8'h00);
    wr(`UC_REG_CTRL, 8'h50);
    rxc(8'h55, 0, 2'h1);
    chk({rx_error_irq_out, rx_full_irq_out}, 2'b10);
    rd(`UC_REG_STAT, 8'h8C);
    wr(`UC_REG_STAT, 8'h00);
    t_end("rx");
    wr(`UC_REG_CFG, 8'h02);
    wr(`UC_REG_CTRL, 8'h58);
    rxc(8'h21, 0, 2'h2);
    chk({rx_error_irq_out, rx_full_irq_out}, 2'b00);
    rd(`UC_REG_STAT, 8'h84);
    rxc(8'h42, 1, 2'h0);
    rd(`UC_REG_CTRL, 8'h50);
    rd(`UC_REG_STAT, 8'hC6);
    rd(`UC_REG_RXD, 8'h42);
    wr(`UC_REG_CFG, 8'h03);
    wr(`UC_REG_CTRL, 8'h58);
    rxc(8'h24, 0, 2'h0);
    rd(`UC_REG_RXD, 8'h24);
    t_end("tag");
    wr(`UC_REG_CFG, 8'h04);
    chk({tx_pin_oe_out, tx_pin_out}, 2'b11);
    tx_serial_in <= 0;
    wr(`UC_REG_CTRL, 8'h20);
    chk({tx_pin_oe_out, tx_pin_out}, 2'b10);
    tx_serial_in <= 1;
    wr(`UC_REG_CFG, 8'h00);
    wr(`UC_REG_CTRL, 8'h20);
    chk(tx_pin_oe_out, 0);
    foreach (ck[i]) begin
      wr(`UC_REG_CTRL, ck[i][7:0]);
      wr(`UC_REG_CFG, {7'h0, ck[i][9]});
      repeat (20) @(posedge core_clk_in);
      chk(serial_clk_pin_oe_out, ck[i][8]);
      chk(link_style_out, ck[i][9]);
    end
    t_end("pins");
    wr(`UC_REG_CFG, 8'h00);
    wr(`UC_REG_CTRL, 8'h10);
    s0 = starts;
    fork
      i_uc_remote_node.send_async(8'hA5);
      begin
        repeat (60) @(posedge core_clk_in);
        chk({rx_serial_out, rx_port_out}, 2'b01);
      end
    join
    chk(starts != s0, 1);
    wr(`UC_REG_CTRL, 8'h12);
    chk(sclk_port_out, 1);
    wr(`UC_REG_CFG, 8'h01);
    s0 = starts;
    i_uc_remote_node.send_sync(8'h3C);
    chk(starts != s0, 1);
    t_end("link");
    report_and_stop();
  end
endmodule
bind uc_serial_control uc_serial_control_monitor i_uc_serial_control_monitor (.core_clk_in, .rst_in,
  .low_power_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
  .s_axi_rvalid_out, .s_axi_awready_out, .s_axi_wready_out, .s_axi_bvalid_out, .half_bit_tick_in,
  .serial_clk_pin_out, .serial_clk_pin_oe_out, .rx_serial_out, .rx_port_out, .rx_start_out, .tx_start_out,
  .tx_holding_out, .tx_empty_irq_out, .rx_full_irq_out, .rx_error_irq_out, .tx_end_irq_out);
